// ---- iaf_defines.svh ----
// constants for the isa host address front end
`ifndef IAF_DEFINES_SVH
`define IAF_DEFINES_SVH
`define IAF_SA_W      17
`define IAF_LA_W      7
`define IAF_ADDR_W    24
`define IAF_LA_LSB    17
`define IAF_ALT_LSB   19
`define IAF_ALT_W     5
`define IAF_PORT_W    4
`define IAF_SYNC_W    31
`define IAF_IRQ_4     4'h4
`define IAF_IRQ_5     4'h5
`define IAF_IRQ_6     4'h6
`define IAF_IRQ_7     4'h7
`define IAF_IRQ_9     4'h9
`define IAF_IRQ_10    4'ha
`define IAF_IRQ_11    4'hb
`define IAF_IRQ_12    4'hc
`define IAF_IRQ_14    4'he
`define IAF_IRQ_15    4'hf
`endif

// ---- iaf_pkg.sv ----
// types for the isa host address front end
package iaf_pkg;
	typedef enum logic [1:0] {IAF_LA_ADDR, IAF_LA_EXTIRQ, IAF_LA_PORT} iaf_la_func_e;
	// static pin configuration, captured while reset is high and frozen once it falls
	typedef struct packed {
		iaf_la_func_e la_func;
		logic         data16;
		logic         irq_encoded;
		logic         memcs_irq;
		logic         iocs_irq;
		logic         rdy_irq;
		logic         sd_irq;
	} iaf_cfg_s;
	// decoded bus cycle
	typedef struct packed {
		logic        mem;
		logic        io;
		logic        rd;
		logic [23:0] addr;
	} iaf_cycle_s;
endpackage

// ---- iaf_front_end.sv ----
// isa host address capture, strap sampling and shared pin muxing
`timescale 1ns/1ns
`include "iaf_defines.svh"

// three-stage pin synchroniser; a bit changes once stages two and three agree
module iaf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] f_r;

	// stage chain, no reset so the strap can be seen during reset
	always_ff @(posedge clk) begin
		s1_r <= din;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// agreement filter
	always_ff @(posedge clk) begin
		f_r <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
	end

	assign dout = f_r;
endmodule

module iaf_front_end
	import iaf_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic [`IAF_SA_W-1:0]      sa_pin,
	input  wire logic [`IAF_LA_W-1:0]      la_pin,
	input  wire logic                      bale_pin,
	input  wire logic                      aen_n_pin,
	input  wire logic                      memr_n_pin,
	input  wire logic                      memw_n_pin,
	input  wire logic                      ior_n_pin,
	input  wire logic                      io_write_and_host_mode_strap,
	input  wire logic                      ref_n_pin,
	input  wire iaf_cfg_s                  cfg_in,
	input  wire logic [`IAF_PORT_W-1:0]    port_a_drive,
	input  wire logic [`IAF_PORT_W-1:0]    port_a_dir,
	input  wire logic                      irq_req,
	input  wire logic [3:0]                irq_line,
	output logic                           isa_mode,
	output iaf_cycle_s                     cycle,
	output logic [`IAF_ALT_W-1:0]          ext_interrupt_inputs,
	output logic [`IAF_PORT_W-1:0]         parallel_port_a_upper,
	output logic [`IAF_PORT_W-1:0]         port_a_out,
	output logic [`IAF_PORT_W-1:0]         port_a_oe,
	output logic [2:0]                     sd_irq_out,
	output logic [2:0]                     sd_irq_oe,
	output logic [2:0]                     ctl_irq_out,
	output logic [2:0]                     ctl_irq_oe,
	output logic [3:0]                     interrupt_level_select,
	output logic [3:0]                     irq_lo_oe,
	output logic                           combined_interrupt_out,
	output logic                           irq15_oe
);
	logic [`IAF_SYNC_W-1:0] pins_f;
	logic [`IAF_SA_W-1:0]   sa_f;
	logic [`IAF_LA_W-1:0]   la_f;
	logic                   bale_f;
	logic                   aen_n_f;
	logic                   memr_n_f;
	logic                   memw_n_f;
	logic                   ior_n_f;
	logic                   iow_n_f;
	logic                   ref_n_f;
	iaf_cfg_s               cfg_r;
	logic                   isa_mode_r;
	logic [`IAF_LA_W-1:0]   la_hold_r;
	logic [`IAF_LA_W-1:0]   la_eff;
	logic                   addr_ok;
	iaf_cycle_s             cycle_r;
	logic [`IAF_ALT_W-1:0]  ext_irq_r;
	logic [`IAF_PORT_W-1:0] port_in_r;
	logic [`IAF_PORT_W-1:0] port_out_r;
	logic [`IAF_PORT_W-1:0] port_oe_r;
	logic [2:0]             sd_out_r;
	logic [2:0]             sd_oe_r;
	logic [2:0]             ctl_out_r;
	logic [2:0]             ctl_oe_r;
	logic [3:0]             lo_out_r;
	logic [3:0]             lo_oe_r;
	logic                   hi_out_r;
	logic                   hi_oe_r;

	// all bus pins come from outside the clock domain
	iaf_sync #(.W(`IAF_SYNC_W)) u_sync (
		.clk  (clk),
		.din  ({sa_pin, la_pin, bale_pin, aen_n_pin, memr_n_pin, memw_n_pin,
		        ior_n_pin, io_write_and_host_mode_strap, ref_n_pin}),
		.dout (pins_f)
	);

	assign {sa_f, la_f, bale_f, aen_n_f, memr_n_f, memw_n_f, ior_n_f, iow_n_f,
	        ref_n_f} = pins_f;

	// strap and pin configuration caught while reset is held
	always_ff @(posedge clk) begin
		if (reset) begin
			isa_mode_r <= iow_n_f;
			cfg_r      <= cfg_in;
		end
	end

	// upper lines follow while enable is high, freeze on its fall
	always_ff @(posedge clk) begin
		if (reset) begin
			la_hold_r <= 7'h00;
		end else if (bale_f) begin
			la_hold_r <= la_f;
		end
	end

	// lines in alternate use read as zero inside the address
	always_comb begin
		la_eff = la_hold_r;
		if (cfg_r.la_func != IAF_LA_ADDR) begin
			la_eff[`IAF_LA_W-1:`IAF_ALT_LSB-`IAF_LA_LSB] = 5'h00;
		end
	end

	// enable low, not a refresh, and isa mode
	assign addr_ok = isa_mode_r && !aen_n_f && ref_n_f;

	// cycle decode; io uses only the static bits
	always_ff @(posedge clk) begin
		if (reset) begin
			cycle_r <= '0;
		end else begin
			cycle_r.mem <= addr_ok && (!memr_n_f || !memw_n_f);
			cycle_r.io  <= addr_ok && (!ior_n_f || !iow_n_f);
			cycle_r.rd  <= !memr_n_f || !ior_n_f;
			if (!memr_n_f || !memw_n_f) begin
				cycle_r.addr <= {la_eff, sa_f};
			end else begin
				cycle_r.addr <= {7'h00, sa_f};
			end
		end
	end

	// alternate inputs on the top latched lines
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_irq_r <= 5'h00;
			port_in_r <= 4'h0;
		end else begin
			ext_irq_r <= (cfg_r.la_func == IAF_LA_EXTIRQ) ? la_f[6:2] : 5'h00;
			port_in_r <= (cfg_r.la_func == IAF_LA_PORT) ? la_f[5:2] : 4'h0;
		end
	end

	// port drive only in port mode; address pins never driven
	always_ff @(posedge clk) begin
		if (reset) begin
			port_out_r <= 4'h0;
			port_oe_r  <= 4'h0;
		end else begin
			port_out_r <= port_a_drive;
			port_oe_r  <= (cfg_r.la_func == IAF_LA_PORT) ? port_a_dir : 4'h0;
		end
	end

	// data pins as requests 5, 6, 14 in 8-bit mode only
	always_ff @(posedge clk) begin
		if (reset) begin
			sd_out_r <= 3'h0;
			sd_oe_r  <= 3'h0;
		end else begin
			sd_out_r <= {irq_req && irq_line == `IAF_IRQ_14,
			             irq_req && irq_line == `IAF_IRQ_6,
			             irq_req && irq_line == `IAF_IRQ_5};
			sd_oe_r  <= {3{cfg_r.sd_irq && !cfg_r.data16 && !cfg_r.irq_encoded}};
		end
	end

	// control outputs as requests 7, 4, 5
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl_out_r <= 3'h0;
			ctl_oe_r  <= 3'h0;
		end else begin
			ctl_out_r <= {irq_req && irq_line == `IAF_IRQ_5,
			              irq_req && irq_line == `IAF_IRQ_4,
			              irq_req && irq_line == `IAF_IRQ_7};
			ctl_oe_r  <= {cfg_r.rdy_irq, cfg_r.iocs_irq, cfg_r.memcs_irq} &
			             {3{!cfg_r.irq_encoded}};
		end
	end

	// dedicated lines 9-12,15 or level code plus combined output
	always_ff @(posedge clk) begin
		if (reset) begin
			lo_out_r <= 4'h0;
			lo_oe_r  <= 4'h0;
			hi_out_r <= 1'b0;
			hi_oe_r  <= 1'b0;
		end else begin
			lo_oe_r  <= {4{isa_mode_r}};
			hi_oe_r  <= isa_mode_r;
			if (cfg_r.irq_encoded) begin
				lo_out_r <= irq_line;
				hi_out_r <= irq_req;
			end else begin
				lo_out_r <= {irq_req && irq_line == `IAF_IRQ_12,
				             irq_req && irq_line == `IAF_IRQ_11,
				             irq_req && irq_line == `IAF_IRQ_10,
				             irq_req && irq_line == `IAF_IRQ_9};
				hi_out_r <= irq_req && irq_line == `IAF_IRQ_15;
			end
		end
	end

	assign isa_mode               = isa_mode_r;
	assign cycle                  = cycle_r;
	assign ext_interrupt_inputs   = ext_irq_r;
	assign parallel_port_a_upper  = port_in_r;
	assign port_a_out             = port_out_r;
	assign port_a_oe              = port_oe_r;
	assign sd_irq_out             = sd_out_r;
	assign sd_irq_oe              = sd_oe_r;
	assign ctl_irq_out            = ctl_out_r;
	assign ctl_irq_oe             = ctl_oe_r;
	assign interrupt_level_select = lo_out_r;
	assign irq_lo_oe              = lo_oe_r;
	assign combined_interrupt_out = hi_out_r;
	assign irq15_oe               = hi_oe_r;

	// checks
	sequence bale_trailing;
		$fell(bale_f) ##1 !bale_f;
	endsequence

	chk_strap_mode: assert property (@(posedge clk) $fell(reset) |-> isa_mode_r == $past(iow_n_f))
		else $error("strap not captured");
	chk_addr_concat: assert property (@(posedge clk) disable iff (reset)
		(!memr_n_f || !memw_n_f) |=> cycle_r.addr == {$past(la_eff), $past(sa_f)})
		else $error("memory address not concatenated");
	chk_addr_input: assert property (@(posedge clk) disable iff (reset)
		cfg_r.la_func != IAF_LA_PORT |=> port_oe_r == 4'h0)
		else $error("address pins driven");
	chk_alt_zero: assert property (@(posedge clk)
		cfg_r.la_func != IAF_LA_ADDR |-> la_eff[6:2] == 5'h00)
		else $error("alternate line leaks into address");
	chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
		bale_trailing |-> la_hold_r == $past(la_hold_r))
		else $error("latch moved after trailing edge");
	chk_io_upper: assert property (@(posedge clk) disable iff (reset)
		cycle_r.io && !cycle_r.mem |-> cycle_r.addr[23:17] == 7'h00)
		else $error("upper bits in io decode");
	chk_aen_gate: assert property (@(posedge clk) disable iff (reset)
		(cycle_r.mem || cycle_r.io) |-> !$past(aen_n_f))
		else $error("cycle taken with enable high");
	chk_sd_width: assert property (@(posedge clk) disable iff (reset)
		sd_oe_r != 3'h0 |-> !cfg_r.data16)
		else $error("data pins taken in 16-bit mode");
	chk_enc_level: assert property (@(posedge clk) disable iff (reset)
		cfg_r.irq_encoded |=> interrupt_level_select == $past(irq_line))
		else $error("level code not shown");
	chk_reset_quiet: assert property (@(posedge clk)
		reset |=> port_oe_r == 4'h0 && sd_oe_r == 3'h0 && ctl_oe_r == 3'h0 && ext_irq_r == 5'h00)
		else $error("shared pins active in reset");
endmodule

// ---- iaf_isa_master.sv ----
// isa bus master model driving the host address and command pins
`timescale 1ns/1ns
module iaf_isa_master (
	input  wire logic clk,
	output logic [16:0] sa_pin,
	output logic [6:0]  la_pin,
	output logic        bale_pin,
	output logic        aen_n_pin,
	output logic        memr_n_pin,
	output logic        memw_n_pin,
	output logic        ior_n_pin,
	output logic        iow_n_pin,
	output logic        ref_n_pin
);
	// idle bus, commands negated, strap pulled high by the board
	initial begin
		sa_pin = 17'h0_0000;
		la_pin = 7'h00;
		bale_pin = 1'b0;
		aen_n_pin = 1'b1;
		memr_n_pin = 1'b1;
		memw_n_pin = 1'b1;
		ior_n_pin = 1'b1;
		iow_n_pin = 1'b1;
		ref_n_pin = 1'b1;
	end
	// strap level seen by the device through reset
	task automatic set_strap(input logic v);
		iow_n_pin <= v;
	endtask
	// refresh cycle marker, blocks any decode while low
	task automatic set_refresh(input logic v);
		ref_n_pin <= v;
	endtask
	// top latched lines used as plain inputs
	task automatic drive_la(input logic [6:0] v);
		@(posedge clk);
		la_pin <= v;
	endtask
	// address phase, then command held with the static lines steady
	task automatic start(input logic mem, input logic wr, input logic aen_n,
			input logic [6:0] la, input logic [16:0] sa);
		@(posedge clk);
		sa_pin <= sa;
		la_pin <= la;
		bale_pin <= 1'b1;
		aen_n_pin <= aen_n;
		repeat (5) @(posedge clk);
		bale_pin <= 1'b0;
		repeat (5) @(posedge clk);
		la_pin <= ~la; // latched lines released after the address phase
		if (mem && wr) begin
			memw_n_pin <= 1'b0;
		end else if (mem) begin
			memr_n_pin <= 1'b0;
		end else if (wr) begin
			iow_n_pin <= 1'b0;
		end else begin
			ior_n_pin <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask
	// end of command; static lines released only afterwards
	task automatic stop();
		@(posedge clk);
		memr_n_pin <= 1'b1;
		memw_n_pin <= 1'b1;
		ior_n_pin <= 1'b1;
		iow_n_pin <= 1'b1;
		aen_n_pin <= 1'b1;
		@(posedge clk);
		sa_pin <= ~sa_pin;
		repeat (7) @(posedge clk);
	endtask
endmodule

// ---- isa_host_address_front_end_tb.sv ----
// self-checking bench for the isa host address front end
`timescale 1ns/1ns
module isa_host_address_front_end_tb;
	import iaf_pkg::*;
	typedef struct packed {
		logic [7:0] cfg;
		logic [3:0] line;
		logic       req;
		logic [2:0] sd;
		logic [2:0] ctl;
		logic [3:0] lvl;
		logic       comb;
	} iaf_row_s;
	logic clk, reset, bale, aen_n, memr_n, memw_n, ior_n, strap, ref_n, irq_req;
	logic isa_mode, comb_out, irq15_oe;
	logic [16:0] sa;
	logic [6:0]  la;
	logic [4:0]  ext_in;
	logic [3:0]  port_drive, port_dir, irq_line, par_a, port_out, port_oe, lvl, irq_lo_oe;
	logic [2:0]  sd_out, sd_oe, ctl_out, ctl_oe;
	iaf_cfg_s    cfg_in;
	iaf_cycle_s  cycle;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cycles = 0;
	// irq table rows: cfg bits {la_func,data16,enc,memcs,iocs,rdy,sd}
	iaf_row_s rows [0:11] = '{'{8'h01, 4'h5, 1'b1, 3'h1, 3'h0, 4'h0, 1'b0},
		'{8'h01, 4'h6, 1'b1, 3'h2, 3'h0, 4'h0, 1'b0}, '{8'h01, 4'he, 1'b1, 3'h4, 3'h0, 4'h0, 1'b0},
		'{8'h21, 4'he, 1'b1, 3'h0, 3'h0, 4'h0, 1'b0}, '{8'h0e, 4'h7, 1'b1, 3'h0, 3'h1, 4'h0, 1'b0},
		'{8'h0e, 4'h4, 1'b1, 3'h0, 3'h2, 4'h0, 1'b0}, '{8'h0e, 4'h5, 1'b1, 3'h0, 3'h4, 4'h0, 1'b0},
		'{8'h00, 4'h9, 1'b1, 3'h0, 3'h0, 4'h1, 1'b0}, '{8'h00, 4'hc, 1'b1, 3'h0, 3'h0, 4'h8, 1'b0},
		'{8'h00, 4'hf, 1'b1, 3'h0, 3'h0, 4'h0, 1'b1}, '{8'h1f, 4'h5, 1'b1, 3'h0, 3'h0, 4'h5, 1'b1},
		'{8'h00, 4'h9, 1'b0, 3'h0, 3'h0, 4'h0, 1'b0}};
	iaf_isa_master host (.clk(clk), .sa_pin(sa), .la_pin(la), .bale_pin(bale),
		.aen_n_pin(aen_n), .memr_n_pin(memr_n), .memw_n_pin(memw_n), .ior_n_pin(ior_n),
		.iow_n_pin(strap), .ref_n_pin(ref_n));
	iaf_front_end dut (.clk(clk), .reset(reset), .sa_pin(sa), .la_pin(la), .bale_pin(bale),
		.aen_n_pin(aen_n), .memr_n_pin(memr_n), .memw_n_pin(memw_n), .ior_n_pin(ior_n),
		.io_write_and_host_mode_strap(strap), .ref_n_pin(ref_n), .cfg_in(cfg_in),
		.port_a_drive(port_drive), .port_a_dir(port_dir), .irq_req(irq_req),
		.irq_line(irq_line), .isa_mode(isa_mode), .cycle(cycle), .ext_interrupt_inputs(ext_in),
		.parallel_port_a_upper(par_a), .port_a_out(port_out), .port_a_oe(port_oe),
		.sd_irq_out(sd_out),
		.sd_irq_oe(sd_oe), .ctl_irq_out(ctl_out), .ctl_irq_oe(ctl_oe),
		.interrupt_level_select(lvl), .irq_lo_oe(irq_lo_oe),
		.combined_interrupt_out(comb_out), .irq15_oe(irq15_oe));
	// clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// compare once outputs have settled after the edge
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		#1;
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// reset long enough for the strap to pass the synchroniser; config is caught directly, not synchronised
	task automatic do_reset(input iaf_cfg_s c, input logic s);
		wait_clk(1);
		reset <= 1'b1;
		cfg_in <= c;
		host.set_strap(s);
		wait_clk(6);
		check("oe in reset", 32'h0, 32'({port_oe, sd_oe, ctl_oe, irq_lo_oe, irq15_oe}));
		wait_clk(1);
		reset <= 1'b0;
		host.set_strap(1'b1);
		wait_clk(3);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		reset = 1'b1;
		cfg_in = 8'h00;
		port_drive = 4'ha;
		port_dir = 4'h5;
		irq_req = 1'b0;
		irq_line = 4'h0;
		// each request pin seen as level gated by its own drive enable
		foreach (rows[i]) begin
			irq_line <= rows[i].line;
			irq_req <= rows[i].req;
			do_reset(rows[i].cfg, 1'b1);
			check("irq outs", 32'(rows[i][10:0]), 32'({sd_out & sd_oe, ctl_out & ctl_oe,
				lvl & irq_lo_oe, comb_out & irq15_oe}));
		end
		$display("done irq table");
		do_reset(8'h00, 1'b1);
		check("isa mode", 32'h1, 32'(isa_mode));
		host.start(1'b1, 1'b0, 1'b0, 7'h5a, 17'h1_2345);
		check("mem cycle", 32'({3'b101, 7'h5a, 17'h1_2345}), 32'(cycle));
		check("port oe addr", 32'h0, 32'(port_oe));
		host.stop();
		host.start(1'b0, 1'b0, 1'b0, 7'h5a, 17'h0_0abc);
		check("io cycle", 32'({3'b011, 7'h00, 17'h0_0abc}), 32'(cycle));
		host.stop();
		host.start(1'b0, 1'b1, 1'b0, 7'h5a, 17'h0_0321);
		check("io write", 32'({3'b010, 7'h00, 17'h0_0321}), 32'(cycle));
		host.stop();
		host.start(1'b1, 1'b0, 1'b1, 7'h11, 17'h0_0001);
		check("aen high", 32'h0, 32'({cycle.mem, cycle.io}));
		host.stop();
		host.set_refresh(1'b0);
		host.start(1'b1, 1'b0, 1'b0, 7'h22, 17'h0_0004);
		check("refresh", 32'h0, 32'({cycle.mem, cycle.io}));
		host.stop();
		host.set_refresh(1'b1);
		$display("done address");
		do_reset(8'h40, 1'b1);
		host.drive_la(7'h6b);
		wait_clk(6);
		check("irq inputs", 32'h1a, 32'(ext_in));
		host.start(1'b1, 1'b1, 1'b0, 7'h7f, 17'h0_0000);
		check("alt write", 32'({3'b100, 7'h03, 17'h0_0000}), 32'(cycle));
		host.stop();
		do_reset(8'h80, 1'b1);
		host.drive_la(7'h2c);
		wait_clk(6);
		check("port a", 32'({5'h00, 4'hb, 4'ha, 4'h5}), 32'({ext_in, par_a, port_out, port_oe}));
		$display("done alternate");
		do_reset(8'h00, 1'b0);
		check("card mode", 32'h0, 32'(isa_mode));
		host.start(1'b1, 1'b0, 1'b0, 7'h01, 17'h0_0002);
		check("no decode", 32'h0, 32'({cycle.mem, cycle.io}));
		host.stop();
		$display("done strap");
		give_verdict();
	end
endmodule
